// file: shared/usmr_pkg.sv
// package: register map, field positions and carrier types of the synchronous serial receiver
// Functional notes
// - master receive turns off the data line output driver
// - master reception starts when single or continuous receive enable is set, slave reception on continuous only
// - single receive clocks one character, then hardware clears single enable
// - continuous receive keeps clocking until software clears continuous enable
// - clearing continuous enable mid-character stops the clock and drops the partial
// - both enables set: single enable clears after first character, continuous goes on
// - data line sampled on each trailing clock edge into the shift register
// - complete character sets receive flag and enters a two-entry fifo
// - receive flag stays set while any unread character remains
// - slave takes its clock from the clock line, clock driver off
// - slave moves one bit per clock, change on leading, valid on trailing
// - third character with full fifo sets overrun, keeps fifo, blocks reception
// - overrun from single receive is cleared by reading receive data
// - overrun from continuous receive cleared by clearing continuous or port enable
// - nine-bit receive shifts nine bits, ninth bit shown of oldest entry
// - receive interrupt request raised only when receive irq enable is set
// - master drives the clock, one cycle per data bit, no start or stop
// - idle polarity set: idle high, data on falling; clear: idle low, rising
// - clocked mode select picks synchronous, clock source master picks master
package usmr_pkg;
  localparam int unsigned AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFF_BAUD_CTL = 8'h00;
  localparam logic [7:0] OFF_RX_DATA  = 8'h04;
  localparam logic [7:0] OFF_RX_STAT  = 8'h08;
  localparam logic [7:0] OFF_DIV_LO   = 8'h0c;
  localparam logic [7:0] OFF_DIV_HI   = 8'h10;
  localparam logic [7:0] OFF_TX_DATA  = 8'h14;
  localparam logic [7:0] OFF_TX_STAT  = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;
  localparam logic [7:0] OFF_FLAGS    = 8'h20;
  // baud_control fields
  localparam int unsigned B_IDLE_POL  = 4;
  localparam int unsigned B_WIDE_CNT  = 3;
  // receive_status_control fields
  localparam int unsigned B_PORT_EN   = 7;
  localparam int unsigned B_RX_NINE   = 6;
  localparam int unsigned B_SINGLE    = 5;
  localparam int unsigned B_CONT      = 4;
  localparam int unsigned B_OVERRUN   = 1;
  localparam int unsigned B_RX_NINTH  = 0;
  // transmit_status_control fields
  localparam int unsigned B_MASTER    = 7;
  localparam int unsigned B_TX_NINE   = 6;
  localparam int unsigned B_TX_EN     = 5;
  localparam int unsigned B_CLOCKED   = 4;
  localparam int unsigned B_HI_SPEED  = 2;
  localparam int unsigned B_TX_IDLE   = 1;
  localparam int unsigned B_TX_NINTH  = 0;
  // irq enable and flag fields
  localparam int unsigned B_RX_IRQ_EN = 0;
  localparam int unsigned B_RX_FLAG   = 0;
  localparam int unsigned B_TX_EMPTY  = 1;
  // answers and reset value
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [3:0] BITS_EIGHT   = 4'h8;
  localparam logic [3:0] BITS_NINE    = 4'h9;

  // serial pin group
  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clk_out;
    logic clk_oe;
  } usmr_pins_t;
endpackage

// file: verilog/usmr_core.sv
// synchronous serial port: master/slave clocking, receive fifo, transmit and axi4-lite slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
module usmr_core (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic [usmr_pkg::AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output      logic                            s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output      logic                            s_axi_wready,
  output      logic [1:0]                      s_axi_bresp,
  output      logic                            s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [usmr_pkg::AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output      logic                            s_axi_arready,
  output      logic [31:0]                     s_axi_rdata,
  output      logic [1:0]                      s_axi_rresp,
  output      logic                            s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            data_line_in,
  input  wire logic                            clock_line_in,
  output      usmr_pkg::usmr_pins_t            pins,
  output      logic                            rx_irq_req
);
  import usmr_pkg::*;

  typedef struct packed {
    logic [2:0]      dl_s;
    logic            dl_f;
    logic [2:0]      cl_s;
    logic            cl_f;
    logic            clock_idle_polarity;
    logic            baud_wide_counter;
    logic [7:0]      brg_lo;
    logic [7:0]      brg_hi;
    logic            serial_port_enable;
    logic            rx9;
    logic            single_receive_enable;
    logic            continuous_receive_enable;
    logic            clock_source_master;
    logic            tx9;
    logic            transmit_enable;
    logic            sync;
    logic            baud_high_speed;
    logic            transmit_ninth_bit;
    logic            receive_irq_enable;
    logic [1:0][8:0] fifo;
    logic [1:0]      cnt;
    logic            overrun_error;
    logic            overrun_error_single;
    logic [8:0]      receive_shift_reg;
    logic [3:0]      bitcnt;
    logic            ph;
    logic [15:0]     brg_cnt;
    logic [8:0]      txbuf;
    logic            txfull;
    logic [8:0]      tsr;
    logic            tx_act;
    logic            dout;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } usmr_state_t;

  usmr_state_t s_q;
  usmr_state_t s_d;

  logic        sync_on;
  logic        master;
  logic        slave;
  logic        rx_mode;
  logic        tx_mode;
  logic        rx_live;
  logic        m_run;
  logic        wr_go;
  logic        rd_go;
  logic [15:0] hp;
  logic        rx_done;
  logic        pop;

  // operating mode decode
  assign sync_on = s_q.serial_port_enable & s_q.sync;
  assign master  = sync_on & s_q.clock_source_master;
  assign slave   = sync_on & ~s_q.clock_source_master;
  assign rx_mode = master ? (s_q.single_receive_enable | s_q.continuous_receive_enable) : s_q.continuous_receive_enable;
  assign tx_mode = ~s_q.single_receive_enable & ~s_q.continuous_receive_enable & s_q.transmit_enable;
  assign rx_live = sync_on & rx_mode & ~s_q.overrun_error;
  assign m_run   = master & (rx_live | (tx_mode & s_q.tx_act));
  assign hp      = s_q.baud_wide_counter ? {s_q.brg_hi, s_q.brg_lo} : {8'h00, s_q.brg_lo};

  // axi handshakes: address and data taken together when no answer is pending
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
  assign rd_go         = s_axi_arvalid & ~s_q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;

  // pins: clock gated at once when the generator stops
  assign pins.clk_out  = (s_q.ph & m_run) ^ s_q.clock_idle_polarity;
  assign pins.clk_oe   = master;
  assign pins.data_out = s_q.dout;
  assign pins.data_oe  = sync_on & tx_mode;
  assign rx_irq_req    = (s_q.cnt != 2'h0) & s_q.receive_irq_enable;

  // next-state logic of the whole block
  always_comb begin
    logic        new_cl;
    logic        sl_edge;
    logic        lead;
    logic        trail;
    logic [3:0]  nbits;
    logic [8:0]  rsr_n;
    logic [8:0]  chr;
    logic [7:0]  wb;
    logic [31:0] rv;
    s_d     = s_q;
    new_cl  = s_q.cl_f;
    sl_edge = 1'b0;
    lead    = 1'b0;
    trail   = 1'b0;
    nbits   = BITS_EIGHT;
    rsr_n   = s_q.receive_shift_reg;
    chr     = 9'h000;
    wb      = s_axi_wdata[7:0];
    rv      = 32'h0000_0000;
    rx_done = 1'b0;
    pop     = 1'b0;

    // three-stage input filters; a change counts when stages two and three agree
    s_d.dl_s = {s_q.dl_s[1:0], data_line_in};
    s_d.cl_s = {s_q.cl_s[1:0], clock_line_in};
    if (s_q.dl_s[1] == s_q.dl_s[2]) begin
      s_d.dl_f = s_q.dl_s[2];
    end
    if (s_q.cl_s[1] == s_q.cl_s[2]) begin
      new_cl = s_q.cl_s[2];
    end
    s_d.cl_f = new_cl;
    sl_edge  = new_cl != s_q.cl_f;

    // answer handshakes retire
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // register read
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_BAUD_CTL: begin
          rv[B_IDLE_POL] = s_q.clock_idle_polarity;
          rv[B_WIDE_CNT] = s_q.baud_wide_counter;
        end
        OFF_RX_DATA: begin
          rv[7:0] = s_q.fifo[0][7:0];
          pop     = s_q.cnt != 2'h0;
        end
        OFF_RX_STAT: begin
          rv[B_PORT_EN]  = s_q.serial_port_enable;
          rv[B_RX_NINE]  = s_q.rx9;
          rv[B_SINGLE]   = s_q.single_receive_enable;
          rv[B_CONT]     = s_q.continuous_receive_enable;
          rv[B_OVERRUN]  = s_q.overrun_error;
          rv[B_RX_NINTH] = s_q.fifo[0][8];
        end
        OFF_DIV_LO:   rv[7:0] = s_q.brg_lo;
        OFF_DIV_HI:   rv[7:0] = s_q.brg_hi;
        OFF_TX_DATA:  rv = 32'h0000_0000;
        OFF_TX_STAT: begin
          rv[B_MASTER]   = s_q.clock_source_master;
          rv[B_TX_NINE]  = s_q.tx9;
          rv[B_TX_EN]    = s_q.transmit_enable;
          rv[B_CLOCKED]  = s_q.sync;
          rv[B_HI_SPEED] = s_q.baud_high_speed;
          rv[B_TX_IDLE]  = ~s_q.tx_act;
          rv[B_TX_NINTH] = s_q.transmit_ninth_bit;
        end
        OFF_IRQ_EN:   rv[B_RX_IRQ_EN] = s_q.receive_irq_enable;
        OFF_FLAGS: begin
          rv[B_RX_FLAG]  = s_q.cnt != 2'h0;
          rv[B_TX_EMPTY] = ~s_q.txfull;
        end
        default:      s_d.rresp = RESP_SLVERR;
      endcase
      s_d.rdata = rv;
    end

    // oldest entry leaves on a data read; a single-mode overrun clears with it
    if (pop) begin
      s_d.fifo[0] = s_q.fifo[1];
      s_d.cnt     = s_q.cnt - 2'h1;
      if (s_q.overrun_error && s_q.overrun_error_single) begin
        s_d.overrun_error = 1'b0;
      end
    end

    // register write, low byte lane only
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        unique case (s_axi_awaddr)
          OFF_BAUD_CTL: begin
            s_d.clock_idle_polarity  = wb[B_IDLE_POL];
            s_d.baud_wide_counter = wb[B_WIDE_CNT];
          end
          OFF_RX_STAT: begin
            s_d.serial_port_enable = wb[B_PORT_EN];
            s_d.rx9  = wb[B_RX_NINE];
            s_d.single_receive_enable = wb[B_SINGLE];
            s_d.continuous_receive_enable = wb[B_CONT];
            if (s_q.continuous_receive_enable && !wb[B_CONT] && s_q.overrun_error && !s_q.overrun_error_single) begin
              s_d.overrun_error = 1'b0;
            end
          end
          OFF_DIV_LO:   s_d.brg_lo = wb;
          OFF_DIV_HI:   s_d.brg_hi = wb;
          OFF_TX_DATA: begin
            s_d.txbuf  = {s_q.transmit_ninth_bit, wb};
            s_d.txfull = 1'b1;
          end
          OFF_TX_STAT: begin
            s_d.clock_source_master = wb[B_MASTER];
            s_d.tx9  = wb[B_TX_NINE];
            s_d.transmit_enable = wb[B_TX_EN];
            s_d.sync = wb[B_CLOCKED];
            s_d.baud_high_speed = wb[B_HI_SPEED];
            s_d.transmit_ninth_bit = wb[B_TX_NINTH];
          end
          OFF_IRQ_EN:   s_d.receive_irq_enable = wb[B_RX_IRQ_EN];
          OFF_RX_DATA, OFF_FLAGS: begin
          end
          default:      s_d.bresp = RESP_SLVERR;
        endcase
      end
    end

    // master clock generator: one full cycle per bit, idle when nothing to move
    if (m_run) begin
      if (s_q.brg_cnt >= hp) begin
        s_d.brg_cnt = 16'h0000;
        s_d.ph      = ~s_q.ph;
        lead        = ~s_q.ph;
        trail       = s_q.ph;
      end else begin
        s_d.brg_cnt = s_q.brg_cnt + 16'h0001;
      end
    end else begin
      s_d.brg_cnt = 16'h0000;
      s_d.ph      = 1'b0;
    end
    // slave edges come from the filtered clock line
    if (slave) begin
      lead  = sl_edge & (new_cl != s_q.clock_idle_polarity);
      trail = sl_edge & (new_cl == s_q.clock_idle_polarity);
    end

    // receive shifter
    if (rx_live) begin
      nbits = s_q.rx9 ? BITS_NINE : BITS_EIGHT;
      if (trail) begin
        rsr_n[s_q.bitcnt] = s_q.dl_f;
        s_d.receive_shift_reg           = rsr_n;
        if (s_q.bitcnt == nbits - 4'h1) begin
          rx_done    = 1'b1;
          s_d.bitcnt = 4'h0;
          s_d.receive_shift_reg    = 9'h000;
          chr        = {rsr_n[8] & s_q.rx9, rsr_n[7:0]};
          if (master && s_q.single_receive_enable) begin
            s_d.single_receive_enable = 1'b0;
          end
          if (s_d.cnt == 2'h2) begin
            s_d.overrun_error        = 1'b1;
            s_d.overrun_error_single = s_q.single_receive_enable & ~s_q.continuous_receive_enable;
          end else begin
            s_d.fifo[s_d.cnt[0]] = chr;
            s_d.cnt              = s_d.cnt + 2'h1;
          end
        end else begin
          s_d.bitcnt = s_q.bitcnt + 4'h1;
        end
      end
    end else if (!s_q.tx_act) begin
      s_d.bitcnt = 4'h0;
      s_d.receive_shift_reg    = 9'h000;
    end

    // transmit shifter: load when idle, change on leading, step on trailing
    if (!(sync_on && tx_mode)) begin
      s_d.tx_act = 1'b0;
    end else if (s_q.tx_act) begin
      nbits = s_q.tx9 ? BITS_NINE : BITS_EIGHT;
      if (lead) begin
        s_d.dout = s_q.tsr[s_q.bitcnt];
      end
      if (trail) begin
        if (s_q.bitcnt == nbits - 4'h1) begin
          s_d.tx_act = 1'b0;
          s_d.bitcnt = 4'h0;
        end else begin
          s_d.bitcnt = s_q.bitcnt + 4'h1;
        end
      end
    end else if (s_q.txfull) begin
      s_d.tsr    = s_q.txbuf;
      s_d.txfull = 1'b0;
      s_d.tx_act = 1'b1;
      s_d.bitcnt = 4'h0;
    end

    // clearing the port enable resets the serial logic
    if (!s_d.serial_port_enable) begin
      s_d.fifo    = '0;
      s_d.cnt     = 2'h0;
      s_d.overrun_error    = 1'b0;
      s_d.receive_shift_reg     = 9'h000;
      s_d.bitcnt  = 4'h0;
      s_d.tx_act  = 1'b0;
      s_d.txfull  = 1'b0;
      s_d.ph      = 1'b0;
      s_d.brg_cnt = 16'h0000;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  rx_drv_off_a: assert property (sync_on && rx_mode |-> !pins.data_oe)
    else $error("data driver on during receive");
  single_stop_a: assert property (rx_done && master && !s_q.continuous_receive_enable |=> !s_q.single_receive_enable && !m_run)
    else $error("single receive did not stop");
  both_en_a: assert property (rx_done && master && s_q.continuous_receive_enable && s_q.single_receive_enable |=> !s_q.single_receive_enable && s_q.continuous_receive_enable)
    else $error("single enable not handed to continuous");
  cont_abort_a: assert property (master && $fell(s_q.continuous_receive_enable) && !s_q.single_receive_enable && !s_q.transmit_enable
      |-> pins.clk_out == s_q.clock_idle_polarity ##1 s_q.bitcnt == 4'h0)
    else $error("clock not stopped on abort");
  fifo_push_a: assert property (rx_done && s_q.cnt == 2'h1 && !pop && s_d.serial_port_enable |=> s_q.cnt == 2'h2)
    else $error("character not queued");
  overrun_keep_a: assert property (rx_done && s_q.cnt == 2'h2 && !pop && s_d.serial_port_enable
      |=> s_q.overrun_error && $stable(s_q.fifo) ##1 !rx_done)
    else $error("overrun lost fifo contents");
  overrun_read_a: assert property (s_q.overrun_error && s_q.overrun_error_single && pop && s_d.serial_port_enable |=> !s_q.overrun_error)
    else $error("read did not clear overrun");
  irq_gate_a: assert property (rx_irq_req |-> s_q.receive_irq_enable && s_q.cnt != 2'h0)
    else $error("receive irq without enable");
  slave_clk_a: assert property (slave |-> !pins.clk_oe)
    else $error("slave drives clock");

  single_cov_c: cover property (rx_done && master && !s_q.continuous_receive_enable ##1 !s_q.single_receive_enable);
  overrun_cov_c: cover property (rx_done && s_q.cnt == 2'h2);
  tx_done_cov_c: cover property ($fell(s_q.tx_act) && sync_on);
endmodule

// file: test/usmr_peer.sv
// behavioural synchronous serial peer: drives the data line and clocks frames as slave master
module usmr_peer (
  input  wire logic       clk_line,
  input  wire logic       idle_pol,
  input  wire logic       peer_clr,
  input  wire logic       slave_go,
  input  wire logic [3:0] nbits,
  input  wire logic [8:0] words [4],
  input  wire logic       dat_line,
  output      logic       data_drv,
  output      logic       pclk,
  output      logic [8:0] cap,
  output      int         lead_cnt,
  output      int         chr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  int   bi;
  // start released, no frame under way
  initial begin
    data_drv = 1'b1;
    cap      = 9'h000;
    ph       = 1'b0;
    lead_cnt = 0;
    chr      = 0;
    bi       = 0;
  end
  // clock of the peer idles at the idle level, toggles only within a frame
  assign pclk = idle_pol ^ ph;
  // as external master give exactly one clock per data bit
  always @(posedge slave_go) begin
    repeat (nbits) begin
      #32 ph = 1'b1;
      #32 ph = 1'b0;
    end
  end
  // change data on each leading edge, release with an inverted level after the frame
  always @(clk_line) begin
    if (clk_line !== idle_pol) begin
      data_drv = words[chr % 4][bi];
      lead_cnt++;
      bi++;
    end else if (bi >= nbits) begin
      bi = 0;
      chr++;
      #40 data_drv = ~data_drv;
    end
  end
  // record the line level at each trailing edge, lowest bit first
  always @(clk_line) if (clk_line === idle_pol) cap = {dat_line, cap[8:1]};
  // restart the bit count after an aborted frame
  always @(posedge peer_clr) bi = 0;
endmodule

// file: test/tb_top.sv
// self-checking bench of the synchronous serial port over axi4-lite
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import usmr_pkg::*;
  localparam logic [7:0] PEN  = 8'h01 << B_PORT_EN;
  localparam logic [7:0] NINE = 8'h01 << B_RX_NINE;
  localparam logic [7:0] SGL  = 8'h01 << B_SINGLE;
  localparam logic [7:0] CONT = 8'h01 << B_CONT;
  localparam logic [7:0] MST  = 8'h01 << B_MASTER;
  localparam logic [7:0] CLKD = 8'h01 << B_CLOCKED;
  localparam logic [7:0] TXN  = (8'h01 << B_TX_EN) | (8'h01 << B_TX_NINE) | (8'h01 << B_TX_NINTH);
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rx_irq_req;
  logic [1:0]  bresp, rresp;
  usmr_pins_t  pins;
  logic        peer_d, pclk, dl, cl, pol = 1'b0, peer_clr = 1'b0, slave_go = 1'b0;
  logic [3:0]  nb = 4'h8;
  logic [8:0]  words [4];
  logic [8:0]  cap;
  int          lead_cnt, chr, errors = 0, n_tests = 0, seed = 32'h5c9ddb4e;
  // clock of the block
  always #4 sys_clk = ~sys_clk;
  // wire levels from whoever drives each pin
  assign dl = pins.data_oe ? pins.data_out : peer_d;
  assign cl = pins.clk_oe ? pins.clk_out : pclk;
  usmr_core DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .data_line_in(dl), .clock_line_in(cl), .pins(pins), .rx_irq_req(rx_irq_req));
  usmr_peer peer (.clk_line(cl), .idle_pol(pol), .peer_clr(peer_clr), .slave_go(slave_go),
    .nbits(nb), .words(words), .dat_line(dl), .data_drv(peer_d), .pclk(pclk), .cap(cap),
    .lead_cnt(lead_cnt), .chr(chr));
  // expected low byte and ninth bit of the k-th character sent by the peer
  function automatic logic [31:0] lo(input int k);
    return {24'h000000, words[k % 4][7:0]};
  endfunction
  function automatic logic nin(input int k);
    return words[k % 4][8];
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("Error at %0t: wait ran out, seen %h expected %h", $time, 32'h0, 32'h1);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // axi4-lite write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    i = 0;
    do begin @(posedge sys_clk); i++; end while (awready !== 1'b1 && i < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && i < 50) begin @(posedge sys_clk); i++; end
    bready <= 1'b0;
    if (i >= 50) tmo();
  endtask
  // axi4-lite read: data and response taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    i = 0;
    do begin @(posedge sys_clk); i++; end while (arready !== 1'b1 && i < 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && i < 50) begin @(posedge sys_clk); i++; end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i >= 50) tmo();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic rbit(input logic [7:0] a, input int b, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({31'h0, d[b]}, {31'h0, e});
  endtask
  // poll one register bit until it reaches the wanted level
  task automatic wait_bit(input logic [7:0] a, input int b, input logic e);
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    d = ~{32{e}};
    for (i = 0; i < 400 && d[b] !== e; i++) rd(a, d, r);
    if (d[b] !== e) tmo();
  endtask
  // one-cycle pulse on a control line of the peer model
  task automatic pulse(ref logic s);
    @(posedge sys_clk);
    s = 1'b1;
    @(posedge sys_clk);
    s = 1'b0;
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    int          i, j, p, k, c;
    for (i = 0; i < 4; i++) words[i] = 9'($random(seed));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    pulse(peer_clr);
    // register reset values, unmapped address, read-write divisor
    rdc(OFF_BAUD_CTL, 32'(REG_RST));
    rdc(OFF_RX_STAT, 32'(REG_RST));
    rdc(OFF_DIV_LO, 32'(REG_RST));
    rdc(OFF_IRQ_EN, 32'(REG_RST));
    rd(8'h24, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h24, 8'h5a);
    chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
    v = 8'($random(seed));
    wr(OFF_DIV_HI, v);
    rdc(OFF_DIV_HI, {24'h0, v});
    $display("test 1 done");
    // three single receptions without reads, in both clock polarities
    wr(OFF_DIV_LO, 8'h07);
    for (p = 0; p < 2; p++) begin
      pol <= p[0];
      wr(OFF_BAUD_CTL, 8'(p) << B_IDLE_POL);
      wr(OFF_IRQ_EN, 8'(p));
      wr(OFF_TX_STAT, MST | CLKD);
      k = chr;
      for (j = 0; j < 3; j++) begin
        c = lead_cnt;
        wr(OFF_RX_STAT, PEN | SGL);
        chk({31'h0, pins.data_oe}, 32'h0);
        chk({31'h0, pins.clk_oe}, 32'h1);
        chk({31'h0, pins.clk_out}, 32'(p));
        wait_bit(OFF_RX_STAT, B_SINGLE, 1'b0);
        chk(32'(lead_cnt - c), 32'(nb));
      end
      chk({31'h0, rx_irq_req}, 32'(p));
      rbit(OFF_RX_STAT, B_OVERRUN, 1'b1);
      rdc(OFF_RX_DATA, lo(k));
      rbit(OFF_RX_STAT, B_OVERRUN, 1'b0);
      rbit(OFF_FLAGS, B_RX_FLAG, 1'b1);
      rdc(OFF_RX_DATA, lo(k + 1));
      rbit(OFF_FLAGS, B_RX_FLAG, 1'b0);
      wr(OFF_RX_STAT, 8'h00);
      pulse(peer_clr);
    end
    $display("test 2 done");
    // continuous nine-bit reception: abort mid-character, then overrun
    nb <= 4'h9;
    pol <= 1'b0;
    wr(OFF_BAUD_CTL, 8'h00);
    c = lead_cnt;
    wr(OFF_RX_STAT, PEN | NINE | CONT);
    for (i = 0; i < 2000 && lead_cnt - c < 4; i++) @(posedge sys_clk);
    if (i >= 2000) tmo();
    wr(OFF_RX_STAT, PEN | NINE);
    c = lead_cnt;
    repeat (60) @(posedge sys_clk);
    chk(32'(lead_cnt), 32'(c));
    rbit(OFF_FLAGS, B_RX_FLAG, 1'b0);
    pulse(peer_clr);
    k = chr;
    wr(OFF_RX_STAT, PEN | NINE | SGL | CONT);
    wait_bit(OFF_RX_STAT, B_OVERRUN, 1'b1);
    rbit(OFF_RX_STAT, B_SINGLE, 1'b0);
    rbit(OFF_RX_STAT, B_RX_NINTH, nin(k));
    rdc(OFF_RX_DATA, lo(k));
    rbit(OFF_RX_STAT, B_RX_NINTH, nin(k + 1));
    rdc(OFF_RX_DATA, lo(k + 1));
    rbit(OFF_FLAGS, B_RX_FLAG, 1'b0);
    rbit(OFF_RX_STAT, B_OVERRUN, 1'b1);
    wr(OFF_RX_STAT, PEN | NINE);
    rbit(OFF_RX_STAT, B_OVERRUN, 1'b0);
    wr(OFF_RX_STAT, 8'h00);
    $display("test 3 done");
    // slave reception on the peer's clock
    nb <= 4'h8;
    wr(OFF_TX_STAT, CLKD);
    wr(OFF_RX_STAT, PEN | CONT);
    chk({31'h0, pins.clk_oe}, 32'h0);
    pulse(peer_clr);
    k = chr;
    pulse(slave_go);
    wait_bit(OFF_FLAGS, B_RX_FLAG, 1'b1);
    rdc(OFF_RX_DATA, lo(k));
    wr(OFF_RX_STAT, 8'h00);
    $display("test 4 done");
    // nine-bit master transmission, captured by the peer on trailing edges
    v = 8'($random(seed));
    wr(OFF_DIV_LO, 8'h07);
    wr(OFF_TX_STAT, MST | CLKD);
    wr(OFF_RX_STAT, PEN);
    wr(OFF_TX_STAT, MST | CLKD | TXN);
    c = lead_cnt;
    wr(OFF_TX_DATA, v);
    chk({31'h0, pins.data_oe}, 32'h1);
    wait_bit(OFF_TX_STAT, B_TX_IDLE, 1'b1);
    chk(32'(lead_cnt - c), 32'h9);
    chk({23'h0, cap}, {24'h000001, v});
    wr(OFF_RX_STAT, 8'h00);
    $display("test 5 done");
    wrap_up();
  end
endmodule
